// ### rtl/u2s_pkg.sv
package u2s_pkg;

  // ==========================================================
  // Cell geometry and pointer sizes
  // ==========================================================
  localparam int U2S_SHORT_BYTES  = 52;
  localparam int U2S_FULL8_BYTES  = 53;
  localparam int U2S_FULL16_BYTES = 54;
  localparam int U2S_CELLS        = 4;
  localparam int U2S_PW           = 3;
  localparam int U2S_CW           = 6;
  localparam int U2S_AW           = 5;
  localparam int U2S_MAW          = 8;
  localparam logic [U2S_PW-1:0] U2S_PTR_RST  = 3'h0;
  localparam logic [U2S_PW-1:0] U2S_FULL_CNT = 3'h4;
  localparam logic [U2S_CW-1:0] U2S_CNT_RST  = 6'h00;

  // ==========================================================
  // Static configuration, one group per direction
  // ==========================================================
  typedef struct packed {
    logic tx_short;
    logic tx_octet;
    logic tx_single;
    logic tx_verify;
    logic tx_discard;
    logic rx_short;
    logic rx_octet;
    logic rx_single;
    logic rx_par_en;
  } u2s_cfg_s;

  // ==========================================================
  // State on the UTOPIA clock
  // ==========================================================
  typedef struct packed {
    u2s_cfg_s          cfg_sy1;
    u2s_cfg_s          cfg_sy2;
    logic [U2S_AW-1:0] tx_addr;
    logic              tx_enb_d;
    logic              tx_sel;
    logic              tx_clav;
    logic              tx_clav_oe_n;
    logic              tx_incell;
    logic              tx_bad;
    logic [U2S_CW-1:0] tx_cnt;
    logic [U2S_PW-1:0] tx_wptr;
    logic [U2S_PW-1:0] tx_gwptr;
    logic [U2S_PW-1:0] tx_rsy1;
    logic [U2S_PW-1:0] tx_rsy2;
    logic              tx_good_p;
    logic              tx_bad_p;
    logic [U2S_AW-1:0] rx_addr;
    logic              rx_enb_d;
    logic              rx_sel;
    logic              rx_clav;
    logic              rx_clav_oe_n;
    logic              rx_incell;
    logic [U2S_CW-1:0] rx_cnt;
    logic [U2S_PW-1:0] rx_rptr;
    logic [U2S_PW-1:0] rx_grptr;
    logic [U2S_PW-1:0] rx_wsy1;
    logic [U2S_PW-1:0] rx_wsy2;
    logic [15:0]       rx_data;
    logic              rx_prty;
    logic              rx_soc;
    logic              rx_oe_n;
  } u2s_utp_s;

  // ==========================================================
  // State on the local-bus clock
  // ==========================================================
  typedef struct packed {
    u2s_cfg_s          cfg_sy1;
    u2s_cfg_s          cfg_sy2;
    logic [U2S_PW-1:0] tx_rptr;
    logic [U2S_PW-1:0] tx_grptr;
    logic [U2S_PW-1:0] tx_wsy1;
    logic [U2S_PW-1:0] tx_wsy2;
    logic [U2S_CW-1:0] tx_cnt;
    logic              tx_valid;
    logic              tx_soc;
    logic [15:0]       tx_data;
    logic [U2S_PW-1:0] rx_wptr;
    logic [U2S_PW-1:0] rx_gwptr;
    logic [U2S_PW-1:0] rx_rsy1;
    logic [U2S_PW-1:0] rx_rsy2;
    logic [U2S_CW-1:0] rx_cnt;
    logic              rx_incell;
    logic              rx_ready;
  } u2s_loc_s;

  function automatic logic [U2S_PW-1:0] u2s_b2g(input logic [U2S_PW-1:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [U2S_PW-1:0] u2s_g2b(input logic [U2S_PW-1:0] g);
    logic [U2S_PW-1:0] b;
    b = g ^ (g >> 1) ^ (g >> 2);
    return b;
  endfunction

  // Words per cell for the chosen length and bus width
  function automatic logic [U2S_CW-1:0] u2s_len_words(input logic short_cell,
                                                      input int   uw);
    int bytes;
    bytes = short_cell ? U2S_SHORT_BYTES
          : ((uw == 8) ? U2S_FULL8_BYTES : U2S_FULL16_BYTES);
    return U2S_CW'(bytes / (uw / 8));
  endfunction

endpackage

// ### rtl/u2s_top.sv
`timescale 1ns/100ps
// Notes on behaviour
// - UTOPIA and local data widths are 8 or 16 bits by parameter.
// - Each direction runs single-port octet/cell handshake or multi-port cell.
// - Multi-port mode reports readiness on one shared tri-state clav line.
// - Master polls transmitter; transmitter answers whether it accepts a cell.
// - Transmitter discards a whole cell cut short by a new start of cell.
// - Transmitter keeps overlong cells and drops bytes past the cell length.
// - Transmitter checks parity if enabled; drops bad cells if discard enabled.
// - Master polls receiver; receiver answers whether it holds a cell.
// - Receiver drives parity on each data word when parity output enabled.
// - Each direction buffers four complete cells.
// - Cell length per direction: 52 bytes, or 53 (8-bit) / 54 (16-bit).
// - UTOPIA and local sides use own clocks; data crosses via cell FIFOs.
// - Transmit cells go to local bus; local cells go out to master.
// - In multi-port mode each direction answers only its own build-time port address; single-port mode answers any address.
// - Multi-port bus serves up to 32 port addresses.
// - One-cycle pulses mark each good and each errored transmit cell.
// - Transmitter and receiver share no control state or settings.
module u2s_top
  import u2s_pkg::*;
#(
  parameter int                UW      = 16,
  parameter int                LW      = 16,
  parameter logic [U2S_AW-1:0] TX_ADDR = 5'h00,
  parameter logic [U2S_AW-1:0] RX_ADDR = 5'h00
) (
  input  wire logic              ref_clk_in,
  input  wire logic              utp_clk_in,
  input  wire logic              sys_rst_in,
  input  wire u2s_cfg_s          cfg_in,
  input  wire logic [UW-1:0]     utx_data_in,
  input  wire logic              utx_prty_in,
  input  wire logic              utx_soc_in,
  input  wire logic              utx_enb_n_in,
  input  wire logic [U2S_AW-1:0] utx_addr_in,
  output      logic              utx_clav_out,
  output      logic              utx_clav_oe_n_out,
  input  wire logic              urx_enb_n_in,
  input  wire logic [U2S_AW-1:0] urx_addr_in,
  output      logic [UW-1:0]     urx_data_out,
  output      logic              urx_prty_out,
  output      logic              urx_soc_out,
  output      logic              urx_data_oe_n_out,
  output      logic              urx_clav_out,
  output      logic              urx_clav_oe_n_out,
  output      logic [LW-1:0]     ltx_data_out,
  output      logic              ltx_soc_out,
  output      logic              ltx_valid_out,
  input  wire logic              ltx_ready_in,
  input  wire logic [LW-1:0]     lrx_data_in,
  input  wire logic              lrx_soc_in,
  input  wire logic              lrx_valid_in,
  output      logic              lrx_ready_out,
  output      logic              tx_good_cell_out,
  output      logic              tx_bad_cell_out
);

  // ==========================================================
  // Cell memories: four slots of 64 words per direction
  // ==========================================================
  // Slots are padded to 64 words so an address is {slot, word}; this
  // wastes over half the RAM with 16-bit cells but avoids a multiplier in both clock domains.
  localparam int DEPTH = U2S_CELLS * (2 ** U2S_CW);

  logic [UW-1:0] tx_mem [0:DEPTH-1];
  logic [UW-1:0] rx_mem [0:DEPTH-1];

  u2s_utp_s u_r;
  u2s_utp_s u_nxt;
  u2s_loc_s l_r;
  u2s_loc_s l_nxt;

  logic               tx_we;
  logic [U2S_MAW-1:0] tx_waddr;
  logic               rx_we;
  logic [U2S_MAW-1:0] rx_waddr;

  always_ff @(posedge utp_clk_in) begin
    if (tx_we) begin
      tx_mem[tx_waddr] <= utx_data_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rx_we) begin
      rx_mem[rx_waddr] <= UW'(lrx_data_in);
    end
  end

  // ==========================================================
  // UTOPIA domain
  // ==========================================================
  logic [U2S_CW-1:0] utx_len;
  logic [U2S_CW-1:0] urx_len;
  logic [U2S_PW-1:0] utx_fill;
  logic [U2S_PW-1:0] urx_fill;
  logic              utx_fall;
  logic              utx_sel_eff;
  logic              utx_acc;
  logic              utx_perr;
  logic              utx_last;
  logic              utx_bad_now;
  logic              urx_fall;
  logic              urx_sel_eff;
  logic [UW-1:0]     urx_word;

  always_comb begin
    u_nxt       = u_r;
    u_nxt.cfg_sy1 = cfg_in;
    u_nxt.cfg_sy2 = u_r.cfg_sy1;
    tx_we       = 1'b0;
    tx_waddr    = {u_r.tx_wptr[1:0], u_r.tx_cnt};
    utx_last    = 1'b0;
    utx_bad_now = 1'b0;
    u_nxt.tx_good_p = 1'b0;
    u_nxt.tx_bad_p  = 1'b0;

    // ---------------- transmitter ----------------
    utx_len  = u2s_len_words(u_r.cfg_sy2.tx_short, UW);
    u_nxt.tx_rsy1 = l_r.tx_grptr;
    u_nxt.tx_rsy2 = u_r.tx_rsy1;
    utx_fill = u_r.tx_wptr - u2s_g2b(u_r.tx_rsy2);
    u_nxt.tx_addr  = utx_addr_in;
    u_nxt.tx_enb_d = utx_enb_n_in;

    // The cell being filled holds a slot that is not yet committed
    if (u_r.cfg_sy2.tx_octet) begin
      u_nxt.tx_clav = (u_r.tx_incell && (u_r.tx_cnt < utx_len))
                    || (utx_fill != U2S_FULL_CNT);
    end else begin
      u_nxt.tx_clav = (utx_fill + U2S_PW'(u_r.tx_incell))
                    < U2S_FULL_CNT;
    end

    // Selection follows the address seen the cycle before enable falls
    utx_fall    = !utx_enb_n_in && u_r.tx_enb_d;
    utx_sel_eff = u_r.tx_sel;
    if (u_r.cfg_sy2.tx_single) begin
      utx_sel_eff        = 1'b1;
      u_nxt.tx_clav_oe_n = 1'b0;
    end else begin
      u_nxt.tx_clav_oe_n = (utx_addr_in != TX_ADDR);
      if (utx_fall) begin
        utx_sel_eff = (u_r.tx_addr == TX_ADDR);
      end
    end
    u_nxt.tx_sel = utx_sel_eff;

    utx_acc  = utx_sel_eff && !utx_enb_n_in;
    utx_perr = u_r.cfg_sy2.tx_verify
             && !(^{utx_prty_in, utx_data_in});

    if (utx_acc && utx_soc_in) begin
      if (u_r.tx_incell) begin
        u_nxt.tx_bad_p = 1'b1;
      end
      u_nxt.tx_incell = (utx_fill != U2S_FULL_CNT);
      u_nxt.tx_cnt    = 6'h01;
      u_nxt.tx_bad    = utx_perr;
      tx_waddr        = {u_r.tx_wptr[1:0], U2S_CNT_RST};
      tx_we           = (utx_fill != U2S_FULL_CNT);
    end else if (utx_acc && u_r.tx_incell) begin
      // Words past the cell length never reach here: the cell is closed
      tx_we        = 1'b1;
      u_nxt.tx_cnt = U2S_CW'(u_r.tx_cnt + 6'h01);
      utx_bad_now  = u_r.tx_bad || utx_perr;
      u_nxt.tx_bad = utx_bad_now;
      utx_last     = (U2S_CW'(u_r.tx_cnt + 6'h01) == utx_len);
    end

    if (utx_last) begin
      u_nxt.tx_incell = 1'b0;
      u_nxt.tx_good_p = !utx_bad_now;
      u_nxt.tx_bad_p  = utx_bad_now;
      if (!(utx_bad_now && u_r.cfg_sy2.tx_discard)) begin
        u_nxt.tx_wptr = U2S_PW'(u_r.tx_wptr + 3'h1);
      end
    end
    u_nxt.tx_gwptr = u2s_b2g(u_nxt.tx_wptr);

    // ---------------- receiver ----------------
    urx_len  = u2s_len_words(u_r.cfg_sy2.rx_short, UW);
    u_nxt.rx_wsy1 = l_r.rx_gwptr;
    u_nxt.rx_wsy2 = u_r.rx_wsy1;
    urx_fill = u2s_g2b(u_r.rx_wsy2) - u_r.rx_rptr;
    u_nxt.rx_addr  = urx_addr_in;
    u_nxt.rx_enb_d = urx_enb_n_in;

    if (u_r.cfg_sy2.rx_octet) begin
      u_nxt.rx_clav = (urx_fill != U2S_PTR_RST);
    end else begin
      u_nxt.rx_clav = (urx_fill > U2S_PW'(u_r.rx_incell));
    end

    urx_fall    = !urx_enb_n_in && u_r.rx_enb_d;
    urx_sel_eff = u_r.rx_sel;
    if (u_r.cfg_sy2.rx_single) begin
      urx_sel_eff        = 1'b1;
      u_nxt.rx_clav_oe_n = 1'b0;
    end else begin
      u_nxt.rx_clav_oe_n = (urx_addr_in != RX_ADDR);
      if (urx_fall) begin
        urx_sel_eff = (u_r.rx_addr == RX_ADDR);
      end
    end
    u_nxt.rx_sel  = urx_sel_eff;
    u_nxt.rx_oe_n = !urx_sel_eff;

    urx_word = rx_mem[{u_r.rx_rptr[1:0], u_r.rx_cnt}];
    if (urx_sel_eff && !urx_enb_n_in) begin
      u_nxt.rx_soc = 1'b0;
      if (u_r.rx_incell || (urx_fill != U2S_PTR_RST)) begin
        u_nxt.rx_data   = 16'(urx_word);
        u_nxt.rx_prty   = u_r.cfg_sy2.rx_par_en
                        && !(^urx_word);
        u_nxt.rx_soc    = !u_r.rx_incell;
        u_nxt.rx_incell = 1'b1;
        u_nxt.rx_cnt    = U2S_CW'(u_r.rx_cnt + 6'h01);
        if (U2S_CW'(u_r.rx_cnt + 6'h01) == urx_len) begin
          u_nxt.rx_incell = 1'b0;
          u_nxt.rx_cnt    = U2S_CNT_RST;
          u_nxt.rx_rptr   = U2S_PW'(u_r.rx_rptr + 3'h1);
        end
      end
    end
    u_nxt.rx_grptr = u2s_b2g(u_nxt.rx_rptr);
  end

  always_ff @(posedge utp_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      u_r              <= '0;
      u_r.tx_enb_d     <= 1'b1;
      u_r.tx_clav_oe_n <= 1'b1;
      u_r.rx_enb_d     <= 1'b1;
      u_r.rx_clav_oe_n <= 1'b1;
      u_r.rx_oe_n      <= 1'b1;
    end else begin
      u_r <= u_nxt;
    end
  end

  // ==========================================================
  // Local-bus domain
  // ==========================================================
  logic [U2S_CW-1:0] ltx_len;
  logic [U2S_CW-1:0] lrx_len;
  logic [U2S_PW-1:0] ltx_fill;
  logic [U2S_PW-1:0] lrx_rbin;
  logic [UW-1:0]     ltx_word;
  logic              lrx_acc;

  always_comb begin
    l_nxt         = l_r;
    l_nxt.cfg_sy1 = cfg_in;
    l_nxt.cfg_sy2 = l_r.cfg_sy1;
    rx_we         = 1'b0;
    rx_waddr      = {l_r.rx_wptr[1:0], l_r.rx_cnt};

    // ---------------- transmit drain ----------------
    ltx_len  = u2s_len_words(l_r.cfg_sy2.tx_short, UW);
    l_nxt.tx_wsy1 = u_r.tx_gwptr;
    l_nxt.tx_wsy2 = l_r.tx_wsy1;
    ltx_fill = u2s_g2b(l_r.tx_wsy2) - l_r.tx_rptr;
    ltx_word = tx_mem[{l_r.tx_rptr[1:0], l_r.tx_cnt}];
    if (!l_r.tx_valid || ltx_ready_in) begin
      l_nxt.tx_valid = (ltx_fill != U2S_PTR_RST);
      if (ltx_fill != U2S_PTR_RST) begin
        l_nxt.tx_data = 16'(ltx_word);
        l_nxt.tx_soc  = (l_r.tx_cnt == U2S_CNT_RST);
        l_nxt.tx_cnt  = U2S_CW'(l_r.tx_cnt + 6'h01);
        if (U2S_CW'(l_r.tx_cnt + 6'h01) == ltx_len) begin
          l_nxt.tx_cnt  = U2S_CNT_RST;
          l_nxt.tx_rptr = U2S_PW'(l_r.tx_rptr + 3'h1);
        end
      end
    end
    l_nxt.tx_grptr = u2s_b2g(l_nxt.tx_rptr);

    // ---------------- receive fill ----------------
    // A start of cell mid-cell restarts the slot, dropping the stub
    lrx_len  = u2s_len_words(l_r.cfg_sy2.rx_short, UW);
    l_nxt.rx_rsy1 = u_r.rx_grptr;
    l_nxt.rx_rsy2 = l_r.rx_rsy1;
    lrx_rbin = u2s_g2b(l_r.rx_rsy2);
    lrx_acc  = lrx_valid_in && l_r.rx_ready;
    if (lrx_acc && lrx_soc_in) begin
      rx_we           = 1'b1;
      rx_waddr        = {l_r.rx_wptr[1:0], U2S_CNT_RST};
      l_nxt.rx_cnt    = 6'h01;
      l_nxt.rx_incell = 1'b1;
    end else if (lrx_acc && l_r.rx_incell) begin
      rx_we        = 1'b1;
      l_nxt.rx_cnt = U2S_CW'(l_r.rx_cnt + 6'h01);
      if (U2S_CW'(l_r.rx_cnt + 6'h01) == lrx_len) begin
        l_nxt.rx_incell = 1'b0;
        l_nxt.rx_wptr   = U2S_PW'(l_r.rx_wptr + 3'h1);
      end
    end
    l_nxt.rx_gwptr = u2s_b2g(l_nxt.rx_wptr);
    // Ready looks at the stale read pointer, so it may lag a free slot
    l_nxt.rx_ready = l_nxt.rx_incell
                   || (U2S_PW'(l_nxt.rx_wptr - lrx_rbin) != U2S_FULL_CNT);
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      l_r <= '0;
    end else begin
      l_r <= l_nxt;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign utx_clav_out      = u_r.tx_clav;
  assign utx_clav_oe_n_out = u_r.tx_clav_oe_n;
  assign urx_data_out      = u_r.rx_data[UW-1:0];
  assign urx_prty_out      = u_r.rx_prty;
  assign urx_soc_out       = u_r.rx_soc;
  assign urx_data_oe_n_out = u_r.rx_oe_n;
  assign urx_clav_out      = u_r.rx_clav;
  assign urx_clav_oe_n_out = u_r.rx_clav_oe_n;
  assign ltx_data_out      = LW'(l_r.tx_data);
  assign ltx_soc_out       = l_r.tx_soc;
  assign ltx_valid_out     = l_r.tx_valid;
  assign lrx_ready_out     = l_r.rx_ready;
  assign tx_good_cell_out  = u_r.tx_good_p;
  assign tx_bad_cell_out   = u_r.tx_bad_p;

endmodule // u2s_top

// ### verification/test_u2s_top.sv
`timescale 1ns/100ps
module test_u2s_top
  import u2s_pkg::*;
;
  // ==========================================================
  // Set-up
  // ==========================================================
  localparam logic [4:0] TA  = 5'h03;
  localparam logic [4:0] RA  = 5'h05;
  localparam int         LEN = U2S_FULL16_BYTES / 2;
  typedef struct {int pre; int n; bit bad; int eg; int eb; int ew;} u2s_row_s;
  u2s_row_s    rows [4] = '{'{0, LEN, 1'b0, 1, 0, LEN}, '{0, LEN + 1, 1'b0, 1, 0, LEN},
                            '{0, LEN, 1'b1, 0, 1, 0}, '{10, LEN, 1'b0, 1, 1, LEN}};
  logic        ref_clk_in, utp_clk_in, sys_rst_in, utx_prty_in, utx_soc_in;
  logic        utx_enb_n_in, utx_clav_out, utx_clav_oe_n_out, urx_enb_n_in;
  logic        urx_prty_out, urx_soc_out, urx_data_oe_n_out, urx_clav_out;
  logic        urx_clav_oe_n_out, ltx_soc_out, ltx_valid_out, ltx_ready_in;
  logic        lrx_soc_in, lrx_valid_in, lrx_ready_out;
  logic        tx_good_cell_out, tx_bad_cell_out;
  logic [15:0] utx_data_in, urx_data_out, ltx_data_out, lrx_data_in;
  logic [4:0]  utx_addr_in, urx_addr_in;
  logic [1:0]  ans;
  logic [16:0] ltx_q [$];
  u2s_cfg_s    cfg_in;
  int          failures = 0, checks = 0, goods = 0, bads = 0;

  initial begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    utp_clk_in = 1'b0;
    #3;
    forever #7.5 utp_clk_in = ~utp_clk_in;
  end

  u2s_top #(.UW(16), .LW(16), .TX_ADDR(TA), .RX_ADDR(RA)) dut_u (.*);
  u2s_atm_model #(.W(16), .TA(TA), .RA(RA)) atm_u (
    .utp_clk_in   (utp_clk_in),
    .rdat_in      (urx_data_out),
    .rprty_in     (urx_prty_out),
    .rsoc_in      (urx_soc_out),
    .tclav_in     (utx_clav_out),
    .tclav_oe_n_in(utx_clav_oe_n_out),
    .rclav_in     (urx_clav_out),
    .rclav_oe_n_in(urx_clav_oe_n_out),
    .tdat_out     (utx_data_in),
    .tprty_out    (utx_prty_in),
    .tsoc_out     (utx_soc_in),
    .tenb_n_out   (utx_enb_n_in),
    .taddr_out    (utx_addr_in),
    .renb_n_out   (urx_enb_n_in),
    .raddr_out    (urx_addr_in)
  );

  // Design outputs seen here still hold their pre-edge values
  always @(posedge utp_clk_in) begin
    goods += (tx_good_cell_out === 1'b1);
    bads += (tx_bad_cell_out === 1'b1);
  end
  always @(posedge ref_clk_in) begin
    if (ltx_valid_out === 1'b1 && ltx_ready_in === 1'b1) ltx_q.push_back({ltx_soc_out, ltx_data_out});
  end

  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic cmp(input logic [16:0] got, input logic [16:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Extra cycles after the target let surplus words show up
  task automatic wait_q(input int n);
    int k;
    k = 0;
    while (ltx_q.size() < n && k < 2000) begin
      @(negedge ref_clk_in);
      k++;
    end
    if (k == 2000) begin
      failures++;
      report_and_stop();
    end
    repeat (20) @(negedge ref_clk_in);
  endtask

  task automatic put_cell(input logic [7:0] tg);
    int k;
    for (int i = 0; i < LEN; i++) begin
      @(negedge ref_clk_in);
      {lrx_valid_in, lrx_soc_in, lrx_data_in} = {1'b1, i == 0, tg, i[7:0]};
      k = 0;
      do begin
        @(posedge ref_clk_in);
        k++;
      end while (lrx_ready_out !== 1'b1 && k < 50);
      if (k == 50) begin
        failures++;
        report_and_stop();
      end
    end
    @(negedge ref_clk_in);
    {lrx_valid_in, lrx_soc_in, lrx_data_in} = {2'b00, ~lrx_data_in};
  endtask

  // ==========================================================
  // Sequence
  // ==========================================================
  initial begin
    sys_rst_in = 1'b1;
    cfg_in = 9'h031; // multi-port cell mode, full cells, parity on, discard
    {ltx_ready_in, lrx_valid_in, lrx_soc_in, lrx_data_in} = 19'h40000;
    #30;
    cmp({9'h000, urx_clav_oe_n_out, utx_clav_oe_n_out, urx_data_oe_n_out, ltx_valid_out,
         lrx_ready_out, tx_good_cell_out, tx_bad_cell_out, urx_soc_out}, 17'h000e0);
    // Release between clock edges: the reset release is not synchronised
    #20;
    sys_rst_in = 1'b0;
    repeat (8) @(negedge utp_clk_in);
    foreach (rows[r]) begin
      ltx_q.delete();
      {goods, bads} = '0;
      if (rows[r].pre > 0) atm_u.send_cell(rows[r].pre, 1'b0, 8'h50);
      atm_u.send_cell(rows[r].n, rows[r].bad, 8'ha0 + 8'(r));
      wait_q(rows[r].ew);
      cmp(17'(goods), 17'(rows[r].eg));
      cmp(17'(bads), 17'(rows[r].eb));
      cmp(17'(ltx_q.size()), 17'(rows[r].ew));
      foreach (ltx_q[i]) cmp(ltx_q[i], {i == 0, 8'ha0 + 8'(r), i[7:0]});
    end
    atm_u.poll(5'h1f, 1'b0, ans);
    cmp({16'h0000, ans[1]}, 17'h00001);
    atm_u.poll(TA, 1'b0, ans);
    cmp({15'h0000, ans}, 17'h00001);
    @(negedge ref_clk_in);
    ltx_ready_in = 1'b0;
    ltx_q.delete();
    repeat (U2S_CELLS) atm_u.send_cell(LEN, 1'b0, 8'hc0);
    atm_u.poll(TA, 1'b0, ans);
    cmp({15'h0000, ans}, 17'h00000);
    atm_u.send_cell(LEN, 1'b0, 8'hc0);
    @(negedge ref_clk_in);
    ltx_ready_in = 1'b1;
    wait_q(U2S_CELLS * LEN);
    cmp(17'(ltx_q.size()), 17'(U2S_CELLS * LEN));
    atm_u.poll(TA, 1'b0, ans);
    cmp({15'h0000, ans}, 17'h00001);
    atm_u.poll(RA, 1'b1, ans);
    cmp({15'h0000, ans}, 17'h00000);
    put_cell(8'h3c);
    repeat (10) @(negedge utp_clk_in);
    atm_u.poll(RA, 1'b1, ans);
    cmp({15'h0000, ans}, 17'h00001);
    atm_u.read_cell(LEN);
    cmp(17'(atm_u.rx_q.size()), 17'(LEN));
    for (int i = 0; i < atm_u.rx_q.size(); i++) begin
      cmp(atm_u.rx_q[i], {~^{8'h3c, i[7:0]}, 8'h3c, i[7:0]});
    end
    report_and_stop();
  end
endmodule // test_u2s_top

// ### verification/u2s_atm_model.sv
`timescale 1ns/100ps
module u2s_atm_model #(
  parameter int         W  = 16,
  parameter logic [4:0] TA = 5'h00,
  parameter logic [4:0] RA = 5'h00
) (
  input  wire logic         utp_clk_in,
  input  wire logic [W-1:0] rdat_in,
  input  wire logic         rprty_in,
  input  wire logic         rsoc_in,
  input  wire logic         tclav_in,
  input  wire logic         tclav_oe_n_in,
  input  wire logic         rclav_in,
  input  wire logic         rclav_oe_n_in,
  output logic [W-1:0]      tdat_out,
  output logic              tprty_out,
  output logic              tsoc_out,
  output logic              tenb_n_out,
  output logic [4:0]        taddr_out,
  output logic              renb_n_out,
  output logic [4:0]        raddr_out
);
  // ==========================================================
  // Bus master behaviour
  // ==========================================================
  logic [W:0] rx_q [$];

  initial begin
    {tdat_out, tprty_out, tsoc_out} = '0;
    {tenb_n_out, renb_n_out} = 2'b11;
    {taddr_out, raddr_out} = 10'h3ff;
  end

  // Address held two cycles so the answer is settled when read
  task automatic poll(input logic [4:0] a, input bit rx, output logic [1:0] ans);
    @(negedge utp_clk_in);
    if (rx) raddr_out = a;
    else taddr_out = a;
    repeat (2) @(negedge utp_clk_in);
    ans = rx ? {rclav_oe_n_in, rclav_in} : {tclav_oe_n_in, tclav_in};
    {taddr_out, raddr_out} = 10'h3ff;
  endtask

  task automatic send_cell(input int n, input bit bad, input logic [7:0] tg);
    @(negedge utp_clk_in);
    taddr_out = TA;
    @(negedge utp_clk_in);
    taddr_out = 5'h1f;
    for (int i = 0; i < n; i++) begin
      tenb_n_out = 1'b0;
      tsoc_out = (i == 0);
      tdat_out = W'({tg, i[7:0]});
      tprty_out = ~^tdat_out ^ (bad && i == 1);
      @(negedge utp_clk_in);
    end
    tenb_n_out = 1'b1;
    tsoc_out = 1'b0;
    // Released lines must not keep showing the last word
    tdat_out = ~tdat_out;
    tprty_out = ~tprty_out;
  endtask

  task automatic read_cell(input int n);
    int k;
    k = 0;
    rx_q.delete();
    @(negedge utp_clk_in);
    raddr_out = RA;
    @(negedge utp_clk_in);
    raddr_out = 5'h1f;
    renb_n_out = 1'b0;
    while (rsoc_in !== 1'b1 && k < 8) begin
      @(negedge utp_clk_in);
      k++;
    end
    repeat (n) begin
      rx_q.push_back({rprty_in, rdat_in});
      @(negedge utp_clk_in);
    end
    renb_n_out = 1'b1;
  endtask
endmodule // u2s_atm_model

// ### verification/u2s_top_chk.sv
`timescale 1ns/100ps
module u2s_top_chk
  import u2s_pkg::*;
#(
  parameter int                UW      = 16,
  parameter int                LW      = 16,
  parameter logic [U2S_AW-1:0] TX_ADDR = 5'h00,
  parameter logic [U2S_AW-1:0] RX_ADDR = 5'h00
) (
  input wire logic              ref_clk_in,
  input wire logic              utp_clk_in,
  input wire logic              sys_rst_in,
  input wire u2s_cfg_s          cfg_in,
  input wire logic [U2S_AW-1:0] utx_addr_in,
  input wire logic              utx_clav_oe_n_out,
  input wire logic              urx_enb_n_in,
  input wire logic [U2S_AW-1:0] urx_addr_in,
  input wire logic [UW-1:0]     urx_data_out,
  input wire logic              urx_prty_out,
  input wire logic              urx_soc_out,
  input wire logic              urx_data_oe_n_out,
  input wire logic              urx_clav_oe_n_out,
  input wire logic [LW-1:0]     ltx_data_out,
  input wire logic              ltx_soc_out,
  input wire logic              ltx_valid_out,
  input wire logic              ltx_ready_in,
  input wire logic              tx_good_cell_out,
  input wire logic              tx_bad_cell_out
);
  // ==========================================================
  // UTOPIA side
  // ==========================================================
  chk_tx_poll_own: assert property (@(posedge utp_clk_in) disable iff (sys_rst_in)
    utx_addr_in == TX_ADDR |-> ##[1:2] !utx_clav_oe_n_out) else $error("tx poll unanswered");
  chk_tx_poll_other: assert property (@(posedge utp_clk_in) disable iff (sys_rst_in)
    (utx_addr_in != TX_ADDR) [*2] |=> utx_clav_oe_n_out) else $error("tx clav driven");
  chk_rx_poll_own: assert property (@(posedge utp_clk_in) disable iff (sys_rst_in)
    urx_addr_in == RX_ADDR |=> ##[0:1] !urx_clav_oe_n_out) else $error("rx poll unanswered");
  chk_rx_poll_other: assert property (@(posedge utp_clk_in) disable iff (sys_rst_in)
    (urx_addr_in != RX_ADDR) [*2] |=> urx_clav_oe_n_out) else $error("rx clav driven");
  chk_rx_odd_parity: assert property (@(posedge utp_clk_in) disable iff (sys_rst_in)
    urx_soc_out && !urx_data_oe_n_out && cfg_in.rx_par_en |-> ^{urx_data_out, urx_prty_out})
    else $error("rx parity not odd");
  chk_rx_soc_once: assert property (@(posedge utp_clk_in) disable iff (sys_rst_in)
    urx_soc_out && !urx_enb_n_in |=> !urx_soc_out) else $error("rx soc too long");
  chk_good_pulse: assert property (@(posedge utp_clk_in) disable iff (sys_rst_in)
    tx_good_cell_out |=> !tx_good_cell_out) else $error("good pulse too long");
  chk_pulse_kind: assert property (@(posedge utp_clk_in) disable iff (sys_rst_in)
    !(tx_good_cell_out && tx_bad_cell_out)) else $error("good and bad together");
  // ==========================================================
  // Local side
  // ==========================================================
  chk_ltx_hold: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    ltx_valid_out && !ltx_ready_in |=> ltx_valid_out && $stable({ltx_soc_out, ltx_data_out}))
    else $error("local word not held");
endmodule // u2s_top_chk

bind u2s_top u2s_top_chk #(.UW(UW), .LW(LW), .TX_ADDR(TX_ADDR), .RX_ADDR(RX_ADDR))
  chk_u (.*);
